/* File: hw/ecl_defs.svh */
`ifndef ECL_DEFS_SVH
`define ECL_DEFS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define ECL_CLK_NS       20
`define ECL_EE_HALF_NS   640
`define ECL_EE_HALF_CYC  (`ECL_EE_HALF_NS / `ECL_CLK_NS)
`define ECL_MDC_HALF_NS  400
`define ECL_MDC_HALF_CYC (`ECL_MDC_HALF_NS / `ECL_CLK_NS)
// ----------------------------------------
// configuration word indices
// ----------------------------------------
`define ECL_W_FLAG     5'h01
`define ECL_W_MAC      5'h04
`define ECL_W_CS_FIRST 5'h07
`define ECL_W_CS_LAST  5'h0E
`define ECL_W_PHYCFG   5'h0F
`define ECL_W_MAXPKT   5'h10
`define ECL_W_PHYID    5'h11
`define ECL_W_WMARK    5'h12
`define ECL_W_CSUM     5'h18
`define ECL_NWORDS     25
// ----------------------------------------
// fields and values
// ----------------------------------------
`define ECL_F_MODE   15:13
`define ECL_F_OFS1   12:8
`define ECL_F_OFS2   4:0
`define ECL_F_MAXPKT 10:0
`define ECL_F_KIND_S 15:13
`define ECL_F_ADDR_S 12:8
`define ECL_F_KIND_P 7:5
`define ECL_F_ADDR_P 4:0
`define ECL_F_HI     15:8
`define ECL_F_LO     7:0
`define ECL_F_SP     0
`define ECL_F_RWU    2
`define ECL_F_DETACH 12
`define ECL_F_PSL    9:8
`define ECL_BLANK    16'hFFFF
`define ECL_CS_BASE  8'hFF
`define ECL_KIND_ETH 3'h0
`define ECL_KIND_NONE 3'h7
`define ECL_MII_BCAST 5'h00
`define ECL_MII_CTRL  5'h00
`define ECL_PWRDN     16'h0800
`define ECL_WM_UNIT_BYTES 128
`define ECL_EE_OP_RD  3'h6
`define ECL_EE_RX_FIRST 5'h0C
`define ECL_EE_LAST   5'h1B
`define ECL_EE_END    5'h1C
`define ECL_MD_END    7'h40
`endif

/* File: hw/ecl_pkg.sv */
package ecl_pkg;
  typedef enum logic [2:0] {
    LM_AN_ALL, LM_AN_100, LM_AN_10, LM_AN_RSVD,
    LM_100_FDX, LM_100_HDX, LM_10_FDX, LM_10_HDX
  } ecl_lmode_t;
  typedef enum logic [2:0] {S_READ, S_CHECK, S_PHY_REL, S_MDIO, S_DONE} ecl_st_t;
  typedef struct packed {
    ecl_st_t           st;
    logic [4:0]        widx;
    logic [1:0]        step;
    logic [24:0][15:0] w;
    logic              rom;
    logic              run;
    logic              ephy_rel;
    logic [2:0]        lm;
    logic [4:0]        lflags;
    logic              fc;
    logic              pause;
    logic              jam;
    logic [15:0]       romq;
  } ecl_top_s_t;
  typedef struct packed {
    logic        busy, cs, sk, ack, s1, s2, s3, dv;
    logic [5:0]  div;
    logic [4:0]  bitn;
    logic [10:0] tx;
    logic [15:0] rx, rdata;
  } ecl_ee_s_t;
  typedef struct packed {
    logic        busy, mdc, ack;
    logic [5:0]  div;
    logic [6:0]  cnt;
    logic [63:0] sh;
  } ecl_md_s_t;
endpackage

/* File: hw/ecl_req_if.sv */
`timescale 1ns/10ps
interface ecl_req_if;
  logic        req;
  logic        ack;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport master (output req, addr, wdata, input ack, rdata);
  modport engine (input req, addr, wdata, output ack, rdata);
endinterface

/* File: hw/ecl_ee_rd.sv */
`timescale 1ns/10ps
`include "ecl_defs.svh"
module ecl_ee_rd (
  input  logic        ref_clk,
  input  logic        nrst,
  ecl_req_if.engine   rq,
  output logic        ee_cs,
  output logic        ee_sk,
  output logic        ee_di,
  input  logic        ee_do
);
  ecl_pkg::ecl_ee_s_t q, n;

  always_comb begin
    n     = q;
    n.ack = 1'b0;
    n.s1  = ee_do;
    n.s2  = q.s1;
    n.s3  = q.s2;
    if (q.s2 == q.s3) begin
      n.dv = q.s3;
    end
    // ack gap keeps a finished request from restarting on stale address
    if (!q.busy) begin
      if (rq.req && !q.ack) begin
        n.busy = 1'b1;
        n.cs   = 1'b1;
        n.sk   = 1'b0;
        n.div  = '0;
        n.bitn = '0;
        n.tx   = {`ECL_EE_OP_RD, rq.addr};
      end
    end else if (q.div == 6'(`ECL_EE_HALF_CYC - 1)) begin
      n.div = '0;
      if (q.bitn == `ECL_EE_END) begin
        n.busy  = 1'b0;
        n.ack   = 1'b1;
        n.rdata = q.rx;
      end else begin
        n.sk = ~q.sk;
        if (q.sk) begin
          n.bitn = q.bitn + 5'h01;
          n.tx   = {q.tx[9:0], 1'b0};
          // cs low for a full half period before the next read
          if (q.bitn == `ECL_EE_LAST) begin
            n.cs = 1'b0;
          end
        end else if (q.bitn >= `ECL_EE_RX_FIRST) begin
          n.rx = {q.rx[14:0], q.dv};
        end
      end
    end else begin
      n.div = q.div + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rq.ack   = q.ack;
  assign rq.rdata = q.rdata;
  assign ee_cs    = q.cs;
  assign ee_sk    = q.sk & q.cs;
  assign ee_di    = q.tx[10] & q.cs;
endmodule

/* File: hw/ecl_mdio_wr.sv */
`timescale 1ns/10ps
`include "ecl_defs.svh"
module ecl_mdio_wr (
  input  logic      ref_clk,
  input  logic      nrst,
  ecl_req_if.engine rq,
  output logic      mdc,
  output logic      mdio_o,
  output logic      mdio_oe
);
  ecl_pkg::ecl_md_s_t q, n;

  always_comb begin
    n     = q;
    n.ack = 1'b0;
    if (!q.busy) begin
      if (rq.req && !q.ack) begin
        n.busy = 1'b1;
        n.mdc  = 1'b0;
        n.div  = '0;
        n.cnt  = '0;
        n.sh   = {32'hFFFF_FFFF, 4'h5, rq.addr[4:0], `ECL_MII_CTRL, 2'h2, rq.wdata};
      end
    end else if (q.div == 6'(`ECL_MDC_HALF_CYC - 1)) begin
      n.div = '0;
      if (q.cnt == `ECL_MD_END) begin
        n.busy = 1'b0;
        n.ack  = 1'b1;
      end else begin
        n.mdc = ~q.mdc;
        // shift on falling edge so data is settled for the rising sample
        if (q.mdc) begin
          n.sh  = {q.sh[62:0], 1'b1};
          n.cnt = q.cnt + 7'h01;
        end
      end
    end else begin
      n.div = q.div + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rq.ack   = q.ack;
  assign rq.rdata = 16'h0000;
  assign mdc      = q.mdc;
  assign mdio_o   = q.sh[63];
  assign mdio_oe  = q.busy && (q.cnt != `ECL_MD_END);
endmodule

/* File: hw/ecl_top.sv */
// Functional notes
// - station address byte 0 is first transmitted octet, byte 5 last
// - offset 1 field picks PHY register for interrupt bytes 5-6, default 00101
// - offset 2 field picks PHY register for interrupt bytes 7-8, default 00000
// - link mode 000 all, 001 100M only, 010 10M only, 011 reserved
// - link modes 100..111 force 100F, 100H, 10F, 10H
// - link mode is latched as the embedded PHY leaves reset
// - PHY kind 000 is supported Ethernet PHY, 111 means none
// - default kind/address bytes are 10h primary and E0h secondary
// - secondary address is the external media interface PHY address
// - full duplex pause starts at high mark, stops at low mark
// - each water mark unit is 128 bytes of receive storage
// - half duplex jamming uses the same two water marks
// - PHY power-down sequence runs only in MAC mode with external PHY
// - three writes to PHY register 0: address 0, primary, secondary
// - WOL ready mode with external PHY skips the power-down sequence
// - blank or bad-checksum EEPROM falls back to the default ROM
// - each default ROM word is low byte first, high byte second
// - default ROM source loads an all-zero station address
// - default ROM holds release number 0002 in both descriptor copies
// - default ROM sets self power, remote wakeup, no detach, level 0
// - default ROM checksum field holds FF
// - checksum valid when it equals FF minus byte sum of words 07-0E
// - 19h configuration words are preloaded from the EEPROM
`timescale 1ns/10ps
`include "ecl_defs.svh"
module ecl_top (
  input  logic        ref_clk,
  input  logic        nrst,
  output logic        ee_cs,
  output logic        ee_sk,
  output logic        ee_di,
  input  logic        ee_do,
  output logic        mdc,
  output logic        mdio_o,
  output logic        mdio_oe,
  input  logic        mac_mode_ext_phy,
  input  logic        wol_ready_en,
  input  logic        full_duplex,
  input  logic [7:0]  free_buf_cnt,
  input  logic [6:0]  rom_addr,
  output logic [15:0] rom_data,
  output logic        cfg_done,
  output logic        cfg_from_rom,
  output logic        core_rst_n,
  output logic        ephy_rst_n,
  output logic [47:0] station_addr,
  output logic [2:0]  phy_link_mode,
  output logic        link_autoneg,
  output logic        link_adv_100,
  output logic        link_adv_10,
  output logic        link_force_100,
  output logic        link_force_fdx,
  output logic [4:0]  intr_phy_ofs1,
  output logic [4:0]  intr_phy_ofs2,
  output logic [10:0] max_frame_size,
  output logic [2:0]  prim_phy_kind,
  output logic [4:0]  prim_phy_bus_address,
  output logic        prim_phy_supported,
  output logic [4:0]  ext_phy_bus_address,
  output logic [7:0]  high_water_mark,
  output logic [7:0]  low_water_mark,
  output logic        pause_req,
  output logic        jam_req,
  output logic        self_powered,
  output logic        remote_wakeup,
  output logic        cable_off_detach,
  output logic [1:0]  psave_level
);
  // ----------------------------------------
  // default ROM
  // ----------------------------------------
  // words written high byte first here; stored bytes read low then high
  function automatic logic [15:0] ecl_rom(input logic [6:0] a);
    case (a)
      7'h00: ecl_rom = 16'h0015;
      7'h01: ecl_rom = 16'h1DFD;
      7'h02: ecl_rom = 16'h1220;
      7'h03: ecl_rom = 16'h2729;
      7'h04: ecl_rom = 16'h0E00;
      7'h05: ecl_rom = 16'h87C6;
      7'h06: ecl_rom = 16'h0172;
      7'h07: ecl_rom = 16'h0409;
      7'h08: ecl_rom = 16'h2260;
      7'h09: ecl_rom = 16'h1271;
      7'h0A: ecl_rom = 16'h0E19;
      7'h0B: ecl_rom = 16'h043D;
      7'h0C: ecl_rom = 16'h043D;
      7'h0D: ecl_rom = 16'h043D;
      7'h0E: ecl_rom = 16'h043D;
      7'h0F: ecl_rom = 16'h0580;
      7'h10: ecl_rom = 16'h0600;
      7'h11: ecl_rom = 16'hE010;
      7'h12: ecl_rom = 16'h2442;
      7'h13: ecl_rom = 16'h1240;
      7'h14: ecl_rom = 16'h2749;
      7'h16: ecl_rom = 16'h0000;
      7'h18: ecl_rom = 16'h08FF;
      7'h26: ecl_rom = 16'h0002;
      7'h46: ecl_rom = 16'h0002;
      default: ecl_rom = 16'hFFFF;
    endcase
  endfunction

  ecl_pkg::ecl_top_s_t q, n;
  ecl_req_if ee ();
  ecl_req_if md ();
  logic [7:0] csum;
  logic       ee_ok;

  ecl_ee_rd u_ee (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .rq      (ee.engine),
    .ee_cs   (ee_cs),
    .ee_sk   (ee_sk),
    .ee_di   (ee_di),
    .ee_do   (ee_do)
  );

  ecl_mdio_wr u_md (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .rq      (md.engine),
    .mdc     (mdc),
    .mdio_o  (mdio_o),
    .mdio_oe (mdio_oe)
  );

  // ----------------------------------------
  // validity check
  // ----------------------------------------
  always_comb begin
    csum = `ECL_CS_BASE;
    for (int i = `ECL_W_CS_FIRST; i <= `ECL_W_CS_LAST; i++) begin
      csum = csum - q.w[i][`ECL_F_LO] - q.w[i][`ECL_F_HI];
    end
    ee_ok = (q.w[0] != `ECL_BLANK) && (csum == q.w[`ECL_W_CSUM][`ECL_F_LO]);
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    n = q;
    n.romq = ecl_rom(rom_addr);
    case (q.st)
      ecl_pkg::S_READ: begin
        if (ee.ack) begin
          n.w[q.widx] = ee.rdata;
          // word 18h closes the 18h-word preload plus checksum word
          if (q.widx == `ECL_W_CSUM) begin
            n.st = ecl_pkg::S_CHECK;
          end else begin
            n.widx = q.widx + 5'h01;
          end
        end
      end
      ecl_pkg::S_CHECK: begin
        if (!ee_ok) begin
          n.rom = 1'b1;
          for (int i = 0; i < `ECL_NWORDS; i++) begin
            n.w[i] = ecl_rom(7'(i));
          end
          n.w[`ECL_W_MAC]     = 16'h0000;
          n.w[`ECL_W_MAC + 1] = 16'h0000;
          n.w[`ECL_W_MAC + 2] = 16'h0000;
        end
        n.lm = n.w[`ECL_W_PHYCFG][`ECL_F_MODE];
        // flags: autoneg, adv100, adv10, force100, forcefdx
        case (ecl_pkg::ecl_lmode_t'(n.lm))
          ecl_pkg::LM_AN_ALL:  n.lflags = 5'b11100;
          ecl_pkg::LM_AN_100:  n.lflags = 5'b11000;
          ecl_pkg::LM_AN_10:   n.lflags = 5'b10100;
          ecl_pkg::LM_AN_RSVD: n.lflags = 5'b11100;
          ecl_pkg::LM_100_FDX: n.lflags = 5'b00011;
          ecl_pkg::LM_100_HDX: n.lflags = 5'b00010;
          ecl_pkg::LM_10_FDX:  n.lflags = 5'b00001;
          default:             n.lflags = 5'b00000;
        endcase
        n.run = mac_mode_ext_phy && !wol_ready_en;
        n.st  = ecl_pkg::S_PHY_REL;
      end
      ecl_pkg::S_PHY_REL: begin
        // mode was settled a cycle earlier, so the PHY sees it at release
        n.ephy_rel = 1'b1;
        n.st = q.run ? ecl_pkg::S_MDIO : ecl_pkg::S_DONE;
      end
      ecl_pkg::S_MDIO: begin
        if (md.ack) begin
          if (q.step == 2'h2) begin
            n.st = ecl_pkg::S_DONE;
          end else begin
            n.step = q.step + 2'h1;
          end
        end
      end
      default: begin
        // marks count free blocks of ECL_WM_UNIT_BYTES each
        if (free_buf_cnt <= q.w[`ECL_W_WMARK][`ECL_F_HI]) begin
          n.fc = 1'b1;
        end else if (free_buf_cnt >= q.w[`ECL_W_WMARK][`ECL_F_LO]) begin
          n.fc = 1'b0;
        end
        n.pause = n.fc && full_duplex;
        n.jam   = n.fc && !full_duplex;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // engine requests
  // ----------------------------------------
  assign ee.req   = (q.st == ecl_pkg::S_READ);
  assign ee.addr  = {3'h0, q.widx};
  assign ee.wdata = 16'h0000;
  assign md.req   = (q.st == ecl_pkg::S_MDIO);
  assign md.wdata = `ECL_PWRDN;
  always_comb begin
    md.addr = 8'h00;
    if (q.step == 2'h0) begin
      md.addr[4:0] = `ECL_MII_BCAST;
    end else if (q.step == 2'h1) begin
      md.addr[4:0] = q.w[`ECL_W_PHYID][`ECL_F_ADDR_P];
    end else begin
      md.addr[4:0] = q.w[`ECL_W_PHYID][`ECL_F_ADDR_S];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cfg_done     = (q.st == ecl_pkg::S_DONE);
  assign core_rst_n   = (q.st == ecl_pkg::S_DONE);
  assign cfg_from_rom = q.rom;
  assign ephy_rst_n   = q.ephy_rel;
  assign rom_data     = q.romq;
  assign station_addr = {q.w[4][`ECL_F_LO], q.w[4][`ECL_F_HI], q.w[5][`ECL_F_LO],
                         q.w[5][`ECL_F_HI], q.w[6][`ECL_F_LO], q.w[6][`ECL_F_HI]};
  assign phy_link_mode  = q.lm;
  assign link_autoneg   = q.lflags[4];
  assign link_adv_100   = q.lflags[3];
  assign link_adv_10    = q.lflags[2];
  assign link_force_100 = q.lflags[1];
  assign link_force_fdx = q.lflags[0];
  assign intr_phy_ofs1  = q.w[`ECL_W_PHYCFG][`ECL_F_OFS1];
  assign intr_phy_ofs2  = q.w[`ECL_W_PHYCFG][`ECL_F_OFS2];
  // passed through as loaded; an odd or oversized value is not corrected
  assign max_frame_size = q.w[`ECL_W_MAXPKT][`ECL_F_MAXPKT];
  assign prim_phy_kind  = q.w[`ECL_W_PHYID][`ECL_F_KIND_P];
  assign prim_phy_bus_address = q.w[`ECL_W_PHYID][`ECL_F_ADDR_P];
  assign prim_phy_supported   = (prim_phy_kind == `ECL_KIND_ETH);
  // secondary kind bits deliberately unused here
  assign ext_phy_bus_address  = q.w[`ECL_W_PHYID][`ECL_F_ADDR_S];
  assign high_water_mark  = q.w[`ECL_W_WMARK][`ECL_F_HI];
  assign low_water_mark   = q.w[`ECL_W_WMARK][`ECL_F_LO];
  assign pause_req        = q.pause;
  assign jam_req          = q.jam;
  assign self_powered     = q.w[`ECL_W_FLAG][`ECL_F_SP];
  assign remote_wakeup    = q.w[`ECL_W_FLAG][`ECL_F_RWU];
  assign cable_off_detach = q.w[`ECL_W_CSUM][`ECL_F_DETACH];
  assign psave_level      = q.w[`ECL_W_CSUM][`ECL_F_PSL];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [5:0] rd_cnt;
  logic [2:0] mw_cnt;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_cnt <= '0;
      mw_cnt <= '0;
    end else begin
      rd_cnt <= rd_cnt + {5'h00, ee.ack};
      mw_cnt <= mw_cnt + {2'h0, md.ack};
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  load_count_a: assert property ($rose(cfg_done) |-> rd_cnt == 6'd25)
    else $error("wrong number of words loaded");
  csum_gate_a: assert property (cfg_done && !cfg_from_rom |-> ee_ok)
    else $error("eeprom data used with bad checksum");
  rom_mac_a: assert property (cfg_done && cfg_from_rom |-> station_addr == 48'h0)
    else $error("rom source gave nonzero address");
  mode_hold_a: assert property ($rose(ephy_rst_n) |-> $stable(phy_link_mode)
    && phy_link_mode == q.w[15][15:13])
    else $error("link mode not settled at phy release");
  pause_on_a: assert property (cfg_done && full_duplex && free_buf_cnt <= high_water_mark
    |=> pause_req && !jam_req)
    else $error("pause not raised at high mark");
  jam_on_a: assert property (cfg_done && !full_duplex && free_buf_cnt <= high_water_mark
    |=> jam_req && !pause_req)
    else $error("jam not raised at high mark");
  fc_off_a: assert property (cfg_done && free_buf_cnt > high_water_mark
    && free_buf_cnt >= low_water_mark |=> !pause_req && !jam_req)
    else $error("flow control not released at low mark");
  first_wr_a: assert property ($rose(md.req) |-> md.addr == 8'h00 ##1 md.req[*8])
    else $error("first power-down write not to address 0");
  seq_cnt_a: assert property ($rose(cfg_done) |-> mw_cnt == (q.run ? 3'd3 : 3'd0))
    else $error("power-down write count wrong");
  core_hold_a: assert property (core_rst_n |-> rd_cnt == 6'd25 && ephy_rst_n)
    else $error("core released before load");

  rom_path_c: cover property ($rose(cfg_done) && cfg_from_rom);
  ee_path_c: cover property ($rose(cfg_done) && !cfg_from_rom);
  mdio_seq_c: cover property ($rose(cfg_done) && mw_cnt == 3'd3);
  pause_c: cover property ($rose(pause_req));
endmodule

/* File: testbench/ecl_ee_model.sv */
`timescale 1ns/10ps
module ecl_ee_model (
  input  wire logic ee_cs,
  input  wire logic ee_sk,
  input  wire logic ee_di,
  output logic      ee_do
);
  logic [15:0] mem [256];
  logic [15:0] sh;
  logic [7:0]  adr;
  logic [2:0]  op;
  int          nbit;

  initial ee_do = 1'b1;

  // ----------------------------------------
  // command in on rising clock
  // ----------------------------------------
  always @(posedge ee_sk) begin
    if (ee_cs) begin
      if (nbit < 3) op = {op[1:0], ee_di};
      else if (nbit < 11) adr = {adr[6:0], ee_di};
      nbit++;
    end
  end

  // ----------------------------------------
  // data out on falling clock
  // ----------------------------------------
  // a wrong opcode answers inverted data, so it cannot pass unseen
  always @(negedge ee_sk) begin
    if (ee_cs) begin
      if (nbit == 11) begin
        sh = (op == 3'b110) ? mem[adr] : ~mem[adr];
        ee_do = 1'b0;
      end else if (nbit >= 12 && nbit <= 27) begin
        ee_do = sh[27 - nbit];
      end else begin
        ee_do = ~ee_do;
      end
    end
  end

  // no pull on the line: a released output flips instead of holding
  always @(ee_cs) begin
    nbit = 0;
    ee_do = ~ee_do;
  end
endmodule

/* File: testbench/eeprom_config_loader_bench.sv */
`timescale 1ns/10ps
module eeprom_config_loader_bench;
  typedef struct packed {
    logic [6:0]  a;
    logic [15:0] d;
  } ecl_row_t;

  logic        ref_clk          = 1'b0;
  logic        nrst             = 1'b0;
  logic        mac_mode_ext_phy = 1'b1;
  logic        wol_ready_en     = 1'b0;
  logic        full_duplex      = 1'b1;
  logic [7:0]  free_buf_cnt     = 8'hFF;
  logic [6:0]  rom_addr         = 7'h00;
  logic        ee_cs, ee_sk, ee_di, ee_do, mdc, mdio_o, mdio_oe;
  logic        cfg_done, cfg_from_rom, core_rst_n, ephy_rst_n;
  logic        link_autoneg, link_adv_100, link_adv_10, link_force_100, link_force_fdx;
  logic        prim_phy_supported, pause_req, jam_req;
  logic        self_powered, remote_wakeup, cable_off_detach;
  logic [1:0]  psave_level;
  logic [2:0]  phy_link_mode, prim_phy_kind;
  logic [4:0]  intr_phy_ofs1, intr_phy_ofs2, prim_phy_bus_address, ext_phy_bus_address;
  logic [7:0]  high_water_mark, low_water_mark;
  logic [10:0] max_frame_size;
  logic [15:0] rom_data;
  logic [47:0] station_addr;
  logic [63:0] mq[$];
  logic [63:0] fr;
  int          nb;
  int          err_total;
  int          tests_run;

  // default rom words, high byte first in the table
  ecl_row_t rows [8] = '{
    '{7'h00, 16'h0015}, '{7'h01, 16'h1DFD}, '{7'h04, 16'h0E00}, '{7'h0F, 16'h0580},
    '{7'h11, 16'hE010}, '{7'h18, 16'h08FF}, '{7'h26, 16'h0002}, '{7'h46, 16'h0002}};

  ecl_top dut (.*);
  ecl_ee_model ee (.*);

  always #10 ref_clk = ~ref_clk;

  always @(posedge mdc) begin
    if (mdio_oe === 1'b1) begin
      fr = {fr[62:0], mdio_o};
      nb++;
      if (nb == 64) begin
        mq.push_back(fr);
        nb = 0;
      end
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [63:0] frm(input logic [4:0] a);
    return {32'hFFFF_FFFF, 4'b0101, a, 5'h00, 2'b10, 16'h0800};
  endfunction

  // ----------------------------------------
  // eeprom image
  // ----------------------------------------
  task automatic fill(input logic bad);
    logic [7:0] s;
    for (int i = 0; i < 256; i++) ee.mem[i] = {8'(i), 8'(i) ^ 8'hA5};
    ee.mem[0] = 16'h0015;
    ee.mem[1] = 16'h0001;
    ee.mem[4] = 16'h2301;
    ee.mem[5] = 16'h6745;
    ee.mem[6] = 16'hAB89;
    ee.mem[15] = 16'hBA83;
    ee.mem[16] = 16'h05EE;
    ee.mem[17] = 16'hEC01;
    ee.mem[18] = 16'h1030;
    s = 8'hFF;
    for (int i = 7; i <= 14; i++) s = s - ee.mem[i][15:8] - ee.mem[i][7:0];
    ee.mem[24] = {8'h13, s + 8'(bad)};
  endtask

  // reset, rom lookups while loading, then bounded waits
  task automatic load(input logic [2:0] mode);
    int n;
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    mq.delete();
    nb = 0;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      rom_addr <= rows[i].a;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(64'(rom_data), 64'(rows[i].d));
    end
    chk(64'({core_rst_n, ephy_rst_n, cfg_done}), 64'h0);
    n = 0;
    while (ephy_rst_n !== 1'b1 && n < 50000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(64'(phy_link_mode), 64'(mode));
    while (cfg_done !== 1'b1 && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
    // a load that never finishes counts as a mismatch here
    chk(64'(cfg_done), 64'h1);
  endtask

  task automatic fc(input logic d, input logic [7:0] f, input logic [1:0] e);
    @(posedge ref_clk);
    full_duplex <= d;
    free_buf_cnt <= f;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(64'({pause_req, jam_req}), 64'(e));
  endtask

  initial begin
    #2_300_000;
    err_total++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fill(1'b0);
    load(3'b101);
    chk(64'(station_addr), 64'h0123_4567_89AB);
    chk(64'({link_autoneg, link_force_100, link_force_fdx}), 64'h2);
    chk(64'({intr_phy_ofs1, intr_phy_ofs2}), 64'h343);
    chk(64'({prim_phy_kind, prim_phy_supported}), 64'h1);
    chk(64'({prim_phy_bus_address, ext_phy_bus_address}), 64'h2C);
    chk(64'({max_frame_size, high_water_mark, low_water_mark}), 64'h05EE_1030);
    chk(64'({self_powered, remote_wakeup, cable_off_detach, psave_level}), 64'h17);
    chk(64'({cfg_from_rom, core_rst_n}), 64'h1);
    chk(64'(mq.size()), 64'h3);
    chk(mq[0], frm(5'h00));
    chk(mq[1], frm(5'h01));
    chk(mq[2], frm(5'h0C));
    // marks are 10h high, 30h low: set at or under high, clear at or over low
    fc(1'b1, 8'h11, 2'b00);
    fc(1'b1, 8'h10, 2'b10);
    fc(1'b1, 8'h2F, 2'b10);
    fc(1'b0, 8'h2F, 2'b01);
    fc(1'b0, 8'h30, 2'b00);
    fc(1'b1, 8'h20, 2'b00);
    // bad checksum by one, wake-ready mode set
    fill(1'b1);
    @(posedge ref_clk);
    wol_ready_en <= 1'b1;
    load(3'b000);
    chk(64'(station_addr), 64'h0);
    chk(64'({link_autoneg, link_adv_100, link_adv_10}), 64'h7);
    chk(64'({intr_phy_ofs1, intr_phy_ofs2}), 64'hA0);
    chk(64'({prim_phy_kind, prim_phy_supported}), 64'h1);
    chk(64'({prim_phy_bus_address, ext_phy_bus_address}), 64'h200);
    chk(64'({max_frame_size, high_water_mark, low_water_mark}), 64'h0600_2442);
    chk(64'({self_powered, remote_wakeup, cable_off_detach, psave_level}), 64'h18);
    chk(64'({cfg_from_rom, core_rst_n}), 64'h3);
    chk(64'(mq.size()), 64'h0);
    summarize();
  end
endmodule
